// >>> hw/tbio_pkg.sv
// package for the timer B-register i/o control block
// assumes a 16-bit counter per channel fed from outside
package tbio_pkg;
	localparam int TBIO_NCH = 3;
	localparam int TBIO_CW = 16;
	localparam int TBIO_AW = 8;
	// register byte addresses
	localparam logic [7:0] TBIO_OFS_CTRL1 = 8'h00;
	localparam logic [7:0] TBIO_OFS_CTRL2 = 8'h04;
	localparam logic [7:0] TBIO_OFS_CTRL3 = 8'h08;
	localparam logic [7:0] TBIO_OFS_AUX = 8'h0C;
	localparam logic [7:0] TBIO_OFS_GRB1 = 8'h10;
	localparam logic [7:0] TBIO_OFS_GRB2 = 8'h14;
	localparam logic [7:0] TBIO_OFS_GRB3 = 8'h18;
	localparam logic [7:0] TBIO_OFS_STAT = 8'h1C;
	// i/o control field positions
	localparam int TBIO_B_FUNC_SEL3 = 7;
	localparam int TBIO_B_FUNC_SEL2 = 6;
	localparam int TBIO_B_FUNC_SEL1 = 5;
	localparam int TBIO_B_FUNC_SEL0 = 4;
	// aux register field positions
	localparam int TBIO_AUX_PSC_LSB = 0;
	localparam int TBIO_AUX_PSC_MSB = 2;
	localparam int TBIO_AUX_BFB = 4;
	// status register field positions
	localparam int TBIO_STAT_PIN_LSB = 0;
	localparam int TBIO_STAT_OEN_LSB = 4;
	// reset values and special codes
	localparam logic [7:0] TBIO_CTRL_RST = 8'h00;
	localparam logic [15:0] TBIO_GRB_RST = 16'h0000;
	localparam logic [2:0] TBIO_PSC_RST = 3'h0;
	localparam logic [2:0] TBIO_PSC_UNDIV = 3'h0;
	// channel indices
	localparam int TBIO_CH1 = 0;
	localparam int TBIO_CH2 = 1;
	localparam int TBIO_CH3 = 2;
	// pin output actions on compare match
	typedef enum logic [1:0] {
		TBIO_ACT_NONE,
		TBIO_ACT_LOW,
		TBIO_ACT_HIGH,
		TBIO_ACT_TOGGLE
	} tbio_act_t;
endpackage

// >>> hw/tbio_edge_det.sv
// two-stage synchroniser plus edge detector for one capture pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module tbio_edge_det import tbio_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// pin sample
	input wire logic pin_in,
	// detected edges
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} tbio_ed_t;

	tbio_ed_t st;
	tbio_ed_t next_st;

	// R13: sync then compare
	always_comb begin
		next_st = st;
		next_st.meta = pin_in;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rise = st.sync & ~st.prev;
	assign fall = ~st.sync & st.prev;
endmodule

// >>> hw/tbio_top.sv
// B-register i/o control for timer channels 1 to 3 behind an APB slave
// assumes counters, count ticks and the channel 0 C-register event
// come from the surrounding timer, all synchronous to sys_clk
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Overview of operation
// R1: bit7 clear: output compare, bit6 initial level
// R2: code x10 drives pin high on match
// R3: code x11 toggles pin on match
// R4: bit7 set: pin capture loads counter
// R5: code 1000 captures on rising edge
// R6: code 1001 captures on falling edge
// R7: code 101x captures on both edges
// R8: channel 1 code 11xx: channel 0 C event
// R9: channel 3 code 11xx: channel 4 count
// R10: undivided channel 4 clock blocks capture
// R11: channel 0 D buffer mode disables events
// R12: control fields reset to zero, read/write
// R13: pin edges synchronised, then compared
// R14: channel 2 code 11xx acts as pin capture
module tbio_top import tbio_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [TBIO_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// counters of channels 1 to 3
	input wire logic [TBIO_NCH-1:0][TBIO_CW-1:0] counter_ch,
	// channel 0 C-register compare match or capture pulse
	input wire logic gen_reg_c_ch0_event,
	// channel 4 count pulse, up or down
	input wire logic counter_ch4_tick,
	// channel 0 D-register event enable
	output logic gen_reg_d_ch0_enable,
	// timer B pins, output enable active low
	input wire logic [TBIO_NCH-1:0] timer_pin_b_in,
	output logic [TBIO_NCH-1:0] timer_pin_b_out,
	output logic [TBIO_NCH-1:0] timer_pin_b_oe_n,
	// capture load pulses for the B registers
	output logic [TBIO_NCH-1:0] capture_pulse
);
	typedef struct packed {
		logic [TBIO_NCH-1:0][7:0] ctrl;
		logic [TBIO_NCH-1:0][TBIO_CW-1:0] grb;
		logic [TBIO_NCH-1:0] pin_lvl;
		logic [TBIO_NCH-1:0] eq_prev;
		logic [TBIO_NCH-1:0] cap;
		logic [2:0] prescale_sel_ch4;
		logic buffer_mode_b;
		logic [31:0] rdata;
		logic err;
	} tbio_st_t;

	tbio_st_t st;
	tbio_st_t next_st;
	logic [TBIO_NCH-1:0] pin_rise;
	logic [TBIO_NCH-1:0] pin_fall;

	// output compare mode test
	function automatic logic is_compare(input logic [7:0] c);
		return ~c[TBIO_B_FUNC_SEL3];
	endfunction

	// pin action on compare match
	function automatic tbio_act_t match_act(input logic [7:0] c);
		unique case (c[TBIO_B_FUNC_SEL1:TBIO_B_FUNC_SEL0])
			2'h0: return TBIO_ACT_NONE;
			2'h1: return TBIO_ACT_LOW;
			2'h2: return TBIO_ACT_HIGH;
			2'h3: return TBIO_ACT_TOGGLE;
		endcase
	endfunction

	// capture decision for pin-sourced codes
	function automatic logic pin_capture(input logic [7:0] c,
			input logic r, input logic f);
		logic hit;
		hit = 1'b0;
		if (c[TBIO_B_FUNC_SEL1]) begin
			hit = r | f;
		end else if (c[TBIO_B_FUNC_SEL0]) begin
			hit = f;
		end else begin
			hit = r;
		end
		return hit;
	endfunction

	// register address decode
	function automatic logic addr_hit(input logic [TBIO_AW-1:0] a);
		unique case (a)
			TBIO_OFS_CTRL1, TBIO_OFS_CTRL2, TBIO_OFS_CTRL3,
			TBIO_OFS_AUX, TBIO_OFS_GRB1, TBIO_OFS_GRB2,
			TBIO_OFS_GRB3, TBIO_OFS_STAT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// register slot i of a block of word registers
	function automatic logic slot_hit(input logic [TBIO_AW-1:0] a,
			input logic [TBIO_AW-1:0] base, input int i);
		return a == base + TBIO_AW'(4 * i);
	endfunction

	// pin enable per channel, low while driving
	function automatic logic [TBIO_NCH-1:0] pin_oe_n_f(
			input logic [TBIO_NCH-1:0][7:0] c);
		logic [TBIO_NCH-1:0] oe_n;
		oe_n = '1;
		for (int i = 0; i < TBIO_NCH; i++) begin
			// R1: code x00 keeps output off
			oe_n[i] = ~(is_compare(c[i]) &&
				(c[i][TBIO_B_FUNC_SEL1:TBIO_B_FUNC_SEL0] != 2'h0));
		end
		return oe_n;
	endfunction

	// capture trigger for one channel
	function automatic logic chan_capture(input int ch,
			input logic [7:0] c, input logic r, input logic f,
			input logic cev, input logic tick,
			input logic [2:0] psc);
		logic hit;
		hit = 1'b0;
		if (is_compare(c)) begin
			hit = 1'b0;
		end else if (!c[TBIO_B_FUNC_SEL2]) begin
			// R4: pin is the source
			// R5: rising edge code
			// R6: falling edge code
			// R7: both edges code
			hit = pin_capture(c, r, f);
		end else if (ch == TBIO_CH1) begin
			// R8: channel 0 C event
			hit = cev;
		end else if (ch == TBIO_CH3) begin
			// R9: channel 4 count source
			// R10: undivided clock blocks it
			hit = tick & (psc != TBIO_PSC_UNDIV);
		end else begin
			// R14: channel 2 falls back to pin
			hit = pin_capture(c, r, f);
		end
		return hit;
	endfunction

	// compare match on entering equality
	function automatic logic match_edge(input logic [7:0] c,
			input logic eq, input logic was_eq, input logic wr);
		return is_compare(c) && eq && !was_eq && !wr;
	endfunction

	// pin level after a compare match
	function automatic logic next_level(input tbio_act_t act,
			input logic lvl);
		logic nl;
		nl = lvl;
		unique case (act)
			// R1: drive low on match
			TBIO_ACT_LOW: nl = 1'b0;
			// R2: drive high on match
			TBIO_ACT_HIGH: nl = 1'b1;
			// R3: invert on match
			TBIO_ACT_TOGGLE: nl = ~lvl;
			TBIO_ACT_NONE: nl = lvl;
		endcase
		return nl;
	endfunction

	// status word: pin levels and enables
	function automatic logic [31:0] stat_word(
			input logic [TBIO_NCH-1:0] lvl,
			input logic [TBIO_NCH-1:0][7:0] c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[TBIO_STAT_PIN_LSB +: TBIO_NCH] = lvl;
		w[TBIO_STAT_OEN_LSB +: TBIO_NCH] = pin_oe_n_f(c);
		return w;
	endfunction

	// read data for one register address
	function automatic logic [31:0] read_word(
			input logic [TBIO_AW-1:0] a,
			input tbio_st_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			TBIO_OFS_CTRL1: w[7:0] = s.ctrl[TBIO_CH1];
			TBIO_OFS_CTRL2: w[7:0] = s.ctrl[TBIO_CH2];
			TBIO_OFS_CTRL3: w[7:0] = s.ctrl[TBIO_CH3];
			TBIO_OFS_AUX: begin
				w[TBIO_AUX_PSC_MSB:TBIO_AUX_PSC_LSB] =
					s.prescale_sel_ch4;
				w[TBIO_AUX_BFB] = s.buffer_mode_b;
			end
			TBIO_OFS_GRB1: w[TBIO_CW-1:0] = s.grb[TBIO_CH1];
			TBIO_OFS_GRB2: w[TBIO_CW-1:0] = s.grb[TBIO_CH2];
			TBIO_OFS_GRB3: w[TBIO_CW-1:0] = s.grb[TBIO_CH3];
			TBIO_OFS_STAT: w = stat_word(s.pin_lvl, s.ctrl);
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	// R13: pin edge detectors
	for (genvar i = 0; i < TBIO_NCH; i++) begin : g_edge
		tbio_edge_det u_edge (
			.sys_clk(sys_clk),
			.rst(rst),
			.pin_in(timer_pin_b_in[i]),
			.rise(pin_rise[i]),
			.fall(pin_fall[i])
		);
	end

	logic setup_ph;
	logic access_wr;
	assign setup_ph = psel & ~penable;
	assign access_wr = psel & penable & pwrite & addr_hit(paddr);

	always_comb begin
		logic [TBIO_NCH-1:0] cap_now;
		logic [TBIO_NCH-1:0] eq_now;
		logic [31:0] rd;
		tbio_act_t act;
		cap_now = '0;
		eq_now = '0;
		rd = 32'h0000_0000;
		act = TBIO_ACT_NONE;
		next_st = st;

		// capture source selection per channel
		for (int i = 0; i < TBIO_NCH; i++) begin
			cap_now[i] = chan_capture(i, st.ctrl[i],
				pin_rise[i], pin_fall[i], gen_reg_c_ch0_event,
				counter_ch4_tick, st.prescale_sel_ch4);
		end

		// apb register writes
		if (access_wr) begin
			unique case (paddr)
				TBIO_OFS_CTRL1, TBIO_OFS_CTRL2, TBIO_OFS_CTRL3: begin
					for (int i = 0; i < TBIO_NCH; i++) begin
						if (slot_hit(paddr, TBIO_OFS_CTRL1, i)) begin
							// R12: field write
							next_st.ctrl[i] = pwdata[7:0];
							// R1: initial level from bit6
							next_st.pin_lvl[i] =
								pwdata[TBIO_B_FUNC_SEL2];
						end
					end
				end
				TBIO_OFS_AUX: begin
					next_st.prescale_sel_ch4 =
						pwdata[TBIO_AUX_PSC_MSB:TBIO_AUX_PSC_LSB];
					next_st.buffer_mode_b = pwdata[TBIO_AUX_BFB];
				end
				TBIO_OFS_GRB1, TBIO_OFS_GRB2, TBIO_OFS_GRB3: begin
					for (int i = 0; i < TBIO_NCH; i++) begin
						if (slot_hit(paddr, TBIO_OFS_GRB1, i)) begin
							next_st.grb[i] = pwdata[TBIO_CW-1:0];
						end
					end
				end
				default: begin
				end
			endcase
		end

		// compare match and capture per channel
		for (int i = 0; i < TBIO_NCH; i++) begin
			eq_now[i] = counter_ch[i] == next_st.grb[i];
			if (match_edge(st.ctrl[i], eq_now[i], st.eq_prev[i],
					access_wr)) begin
				act = match_act(st.ctrl[i]);
				next_st.pin_lvl[i] = next_level(act, st.pin_lvl[i]);
			end
			// R4: counter loads B register, over a bus write
			if (cap_now[i]) begin
				next_st.grb[i] = counter_ch[i];
			end
			next_st.cap[i] = cap_now[i];
			next_st.eq_prev[i] = eq_now[i];
		end

		// read data captured in the setup phase
		rd = read_word(paddr, st);
		if (setup_ph) begin
			next_st.rdata = pwrite ? 32'h0000_0000 : rd;
			next_st.err = ~addr_hit(paddr);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// R12: fields reset to zero
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & st.err;
	assign timer_pin_b_out = st.pin_lvl;
	assign timer_pin_b_oe_n = pin_oe_n_f(st.ctrl);
	assign capture_pulse = st.cap;
	// R11: buffer mode kills D events
	assign gen_reg_d_ch0_enable = ~st.buffer_mode_b;
endmodule

// >>> bench/tbio_pin_model.sv
// far-side model of the three timer b pins
// assumes the block's enable is active low
`timescale 1ns/1ps
module tbio_pin_model (
	// block side
	input wire logic [2:0] oe_n,
	input wire logic [2:0] pin_out,
	// bench side
	input wire logic [2:0] drv,
	output logic [2:0] pin
);
	assign pin = (oe_n & drv) | (~oe_n & pin_out);
endmodule

// >>> bench/tbio_props.sv
// checker on the ports of tbio_top
// assumes one clock domain and a well-behaved apb master
`timescale 1ns/1ps
module tbio_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// timer side
	input wire logic [2:0][15:0] counter_ch,
	input wire logic gen_reg_c_ch0_event,
	input wire logic counter_ch4_tick,
	input wire logic gen_reg_d_ch0_enable,
	input wire logic [2:0] timer_pin_b_in,
	input wire logic [2:0] timer_pin_b_out,
	input wire logic [2:0] timer_pin_b_oe_n,
	input wire logic [2:0] capture_pulse
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic wr = psel & penable & pwrite;
	wire logic w1 = wr && paddr == 8'h00;
	logic [2:0] p1, p2, p3, p4, p5;
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			{p1, p2, p3, p4, p5} <= '0;
		else
			{p1, p2, p3, p4, p5} <= {timer_pin_b_in, p1, p2, p3, p4};
	wire logic [2:0] mv = (p2 ^ p3) | (p3 ^ p4) | (p4 ^ p5);
	a_oe_off: assert property (
		w1 && pwdata[5:4] == 2'h0 |=> timer_pin_b_oe_n[0])
		else $error("pin drive not off");
	a_init_lvl: assert property (
		w1 && !pwdata[7] && pwdata[5:4] != 2'h0 |=> !timer_pin_b_oe_n[0]
		&& timer_pin_b_out[0] == $past(pwdata[6]))
		else $error("initial level wrong");
	a_cap_hiz: assert property (w1 && pwdata[7] |=> timer_pin_b_oe_n[0])
		else $error("capture mode drives pin");
	a_pin_cause: assert property (
		$changed(timer_pin_b_out[0]) |-> $past(wr)
		|| $past(counter_ch[0]) != $past(counter_ch[0], 2))
		else $error("pin moved without cause");
	a_src_ch1: assert property (
		capture_pulse[0] |-> mv[0] || $past(gen_reg_c_ch0_event))
		else $error("ch1 capture without source");
	a_src_ch2: assert property (capture_pulse[1] |-> mv[1])
		else $error("ch2 capture without edge");
	a_src_ch3: assert property (
		capture_pulse[2] |-> mv[2] || $past(counter_ch4_tick))
		else $error("ch3 capture without source");
	a_buf_mode: assert property (wr && paddr == 8'h0C |=>
		gen_reg_d_ch0_enable == !$past(pwdata[4]))
		else $error("buffer mode enable wrong");
	a_rst_vals: assert property (disable iff (1'b0) rst |->
		timer_pin_b_oe_n == 3'h7 && capture_pulse == 3'h0)
		else $error("reset outputs wrong");
endmodule
bind tbio_top tbio_props u_props (.*);

// >>> bench/tb_timer_b_io_control.sv
// testbench for tbio_top: apb master, pin model, timer events
// assumes zero or more apb wait states, bounded by a timeout
`timescale 1ns/1ps
module tb_timer_b_io_control import tbio_pkg::*;;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic cev = 0, tick = 0, pready, pslverr, den, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0][15:0] cnt = '0;
	logic [2:0] drv = 3'h0, pin, pout, poe_n, cap;
	int failures = 0, checked = 0;
	// rows: code, oe_n after write, pin after match
	logic [9:0] rows [8] = '{10'h002, 10'h040, 10'h081, 10'h0C1,
		10'h103, 10'h140, 10'h181, 10'h1C0};
	tbio_top dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .counter_ch(cnt), .gen_reg_c_ch0_event(cev),
		.counter_ch4_tick(tick), .gen_reg_d_ch0_enable(den),
		.timer_pin_b_in(pin), .timer_pin_b_out(pout),
		.timer_pin_b_oe_n(poe_n), .capture_pulse(cap));
	tbio_pin_model pm (.oe_n(poe_n), .pin_out(pout), .drv(drv), .pin(pin));
	always #5 sys_clk = ~sys_clk;
	task automatic wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input int a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= 8'(a);
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			failures++;
			wrap_up();
		end
	endtask
	task automatic cap_t(input int c, input logic [7:0] code,
		input logic lv, input logic ev, input logic e);
		logic got;
		apb(1, c * 4, {24'h0, code});
		drv[c] <= lv;
		cev <= ev;
		tick <= ev;
		got = 0;
		for (int n = 0; n < 8; n++) begin
			@(posedge sys_clk);
			cev <= 0;
			tick <= 0;
			got |= cap[c];
		end
		chk(got, e);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		chk(poe_n, 3'h7);
		chk(den, 1'b1);
		for (int i = 0; i < 3; i++) begin
			apb(0, i * 4, 32'h0);
			chk(rd, 32'h0);
		end
		apb(1, 8'h04, 32'hA5);
		apb(0, 8'h04, 32'h0);
		chk(rd, 32'hA5);
		apb(1, 8'h04, 32'h0);
		apb(0, 8'h20, 32'h0);
		chk(err, 1'b1);
		apb(1, 8'h10, 32'h5);
		foreach (rows[i]) begin
			cnt[0] <= 16'h0;
			apb(1, 8'h00, {24'h0, rows[i][9:2]});
			@(posedge sys_clk);
			chk(poe_n[0], rows[i][1]);
			chk(pout[0], rows[i][8]);
			cnt[0] <= 16'h5;
			repeat (3) @(posedge sys_clk);
			chk(pout[0], rows[i][0]);
		end
		$display("compare table done");
		cnt[0] <= 16'h1234;
		cap_t(0, 8'h80, 1, 0, 1);
		apb(0, 8'h10, 32'h0);
		chk(rd, 32'h1234);
		cap_t(0, 8'h80, 0, 0, 0);
		cap_t(0, 8'h90, 1, 0, 0);
		cap_t(0, 8'h90, 0, 0, 1);
		cap_t(0, 8'hA0, 1, 0, 1);
		cap_t(0, 8'hB0, 0, 0, 1);
		cap_t(1, 8'hC0, 1, 0, 1);
		cap_t(1, 8'hD0, 0, 0, 1);
		cap_t(0, 8'hC0, 0, 1, 1);
		cap_t(2, 8'hC0, 0, 1, 0);
		apb(1, 8'h0C, 32'h1);
		cap_t(2, 8'hC0, 0, 1, 1);
		$display("capture done");
		apb(1, 8'h0C, 32'h11);
		@(posedge sys_clk);
		chk(den, 1'b0);
		apb(1, 8'h0C, 32'h1);
		@(posedge sys_clk);
		chk(den, 1'b1);
		$display("buffer mode done");
		wrap_up();
	end
endmodule
